// ===== inc/dpt_pkg.sv
// Package of constants for the discrete output pulse timer
package dpt_pkg;
  // ******************************************************
  // Bus map
  // ******************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIME_ON = 8'h04;
  localparam logic [7:0] ADDR_TIME_OFF = 8'h08;
  localparam logic [7:0] ADDR_VALUE = 8'h0C;
  localparam logic [7:0] ADDR_STEP = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_TRIG = 8'h18;
  localparam logic [7:0] ADDR_LABEL_ON = 8'h20;
  localparam logic [7:0] ADDR_LABEL_OFF = 8'h30;
  localparam int LABEL_WORDS = 3;
  localparam int LABEL_CHARS = 10;
  // ******************************************************
  // Modes
  // ******************************************************
  localparam logic [1:0] MODE_OTHER = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_ALT = 2'h2;
  localparam logic [1:0] MODE_SCALED = 2'h3;
  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 100;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int DUR_W = 16;
  localparam logic [15:0] DUR_MIN = 16'h0001;
  localparam logic [15:0] DUR_DEFAULT = 16'h0064;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ===== hw/dpt_label_mem.sv
// Small label memory with registered read data
`timescale 1ns/10ps
module dpt_label_mem
  import dpt_pkg::*;
#(
  parameter int DEPTH = 8
)
(
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [2:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== hw/dpt_timer.sv
// Discrete output pulse timer with AHB-Lite register slave
//
// Overview of operation
// R1: On-duration register sets energized time
// R2: Durations clamp to at least one tick
// R3: On and off durations default one second
// R4: Single-pulse mode: one on-duration pulse
// R5: Alternating mode toggles after each on-duration and each off-duration
// R6: Scaled mode pulses per significance step
// R7: Off-duration used only in alternating mode
// R8: Other modes ignore on-duration
// R9: Ten-character labels for both states
// R10: Selected value mirrors output level
// R11: Count 10 ms ticks from clock
`timescale 1ns/10ps
module dpt_timer
  import dpt_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic dout,
  output logic selected_value
);
  // ******************************************************
  // State machine
  // ******************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ON = 3'b010,
    ST_OFF = 3'b100
  } dpt_state_t;

  dpt_state_t state;
  dpt_state_t next_state;
  logic [1:0] mode;
  logic enable;
  logic [DUR_W-1:0] time_on;
  logic [DUR_W-1:0] time_off;
  logic [31:0] value;
  logic [31:0] step;
  logic [31:0] reference;
  logic ref_valid;
  logic [DUR_W-1:0] remain;
  logic [31:0] tick_cnt;
  logic tick;
  logic trig;
  logic ph_wr;
  logic [7:0] ph_addr;
  logic lbl_rd;
  logic [31:0] lbl_data;
  logic lbl_wr;
  logic [3:0] lbl_widx;
  logic [3:0] lbl_ridx;
  logic [2:0] lbl_waddr;
  logic [2:0] lbl_raddr;
  logic scaled_due;
  // Clamp a duration to the minimum tick count
  function automatic logic [DUR_W-1:0] clamp_dur(input logic [31:0] d);
    return (d[DUR_W-1:0] < DUR_MIN) ? DUR_MIN : d[DUR_W-1:0];
  endfunction
  // Label index of a byte address, or invalid
  function automatic logic [3:0] label_index(input logic [7:0] a);
    if (a >= ADDR_LABEL_ON && a < ADDR_LABEL_ON + 8'(4 * LABEL_WORDS))
    begin
      return {2'b10, 2'((a - ADDR_LABEL_ON) >> 2)};
    end
    if (a >= ADDR_LABEL_OFF && a < ADDR_LABEL_OFF + 8'(4 * LABEL_WORDS))
    begin
      return {2'b11, 2'((a - ADDR_LABEL_OFF) >> 2)};
    end
    return 4'h0;
  endfunction
  // ******************************************************
  // Bus slave
  // ******************************************************
  wire logic accept = hsel && hready && htrans == HTRANS_NONSEQ;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ph_wr <= 1'b0;
      ph_addr <= 8'h00;
    end
    else
    begin
      ph_wr <= accept && hwrite;
      ph_addr <= accept ? haddr[7:0] : ph_addr;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      lbl_rd <= 1'b0;
    end
    else
    begin
      hreadyout <= !(accept && !hwrite && lbl_ridx != 4'h0);
      hresp <= 1'b0;
      lbl_rd <= accept && !hwrite && lbl_ridx != 4'h0;
    end
  end
  assign lbl_widx = label_index(ph_addr);
  assign lbl_ridx = label_index(haddr[7:0]);
  assign lbl_wr = ph_wr && lbl_widx != 4'h0; // R9
  assign lbl_waddr = lbl_widx[2:0];
  assign lbl_raddr = lbl_ridx[2:0];
  dpt_label_mem #(
    .DEPTH(8)
  ) u_labels (
    .sys_clk(sys_clk),
    .wr_en(lbl_wr),
    .wr_addr(lbl_waddr),
    .wr_data(hwdata),
    .rd_addr(lbl_raddr),
    .rd_data(lbl_data)
  );
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode <= MODE_OTHER;
      enable <= 1'b0;
      time_on <= DUR_DEFAULT; // R3
      time_off <= DUR_DEFAULT; // R3
      value <= ZERO_WORD;
      step <= ZERO_WORD;
    end
    else if (ph_wr)
    begin
      case (ph_addr)
        ADDR_CTRL:
        begin
          mode <= hwdata[1:0];
          enable <= hwdata[2];
        end
        ADDR_TIME_ON: time_on <= clamp_dur(hwdata); // R1 R2
        ADDR_TIME_OFF: time_off <= clamp_dur(hwdata); // R7 R2
        ADDR_VALUE: value <= hwdata;
        ADDR_STEP: step <= hwdata;
        default: mode <= mode;
      endcase
    end
  end
  assign trig = ph_wr && ph_addr == ADDR_TRIG;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hrdata <= ZERO_WORD;
    end
    else if (lbl_rd)
    begin
      hrdata <= lbl_data; // R9
    end
    else if (accept && !hwrite)
    begin
      case (haddr[7:0])
        ADDR_CTRL: hrdata <= {29'h000_0000, enable, mode};
        ADDR_TIME_ON: hrdata <= {16'h0000, time_on};
        ADDR_TIME_OFF: hrdata <= {16'h0000, time_off};
        ADDR_VALUE: hrdata <= value;
        ADDR_STEP: hrdata <= step;
        ADDR_STATUS: hrdata <= {27'h000_0000, state, selected_value, dout};
        default: hrdata <= ZERO_WORD;
      endcase
    end
  end
  // ******************************************************
  // Tick divider
  // ******************************************************
  always_ff @(posedge sys_clk)
  begin
    tick <= !rst && tick_cnt == 32'(TICK_DIV - 1); // R11
    if (rst || tick_cnt == 32'(TICK_DIV - 1))
    begin
      tick_cnt <= ZERO_WORD;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end
  // ******************************************************
  // Scaled reference
  // ******************************************************
  assign scaled_due = ref_valid && (value - reference) > step; // R6
  always_ff @(posedge sys_clk)
  begin
    if (rst || !enable || mode != MODE_SCALED)
    begin
      ref_valid <= 1'b0;
      reference <= ZERO_WORD;
    end
    else if (!ref_valid)
    begin
      ref_valid <= 1'b1;
      reference <= value;
    end
    else if (state == ST_IDLE && scaled_due)
    begin
      reference <= reference + step; // R6
    end
  end
  // ******************************************************
  // Pulse sequencer
  // ******************************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (enable && (mode == MODE_ALT || (mode == MODE_SINGLE && trig)
          || (mode == MODE_SCALED && scaled_due)))
        begin
          next_state = ST_ON; // R4 R5 R6
        end
      end
      ST_ON:
      begin
        if (!enable || mode == MODE_OTHER)
        begin
          next_state = ST_IDLE; // R8
        end
        else if (tick && remain == DUR_MIN)
        begin
          next_state = mode == MODE_ALT ? ST_OFF : ST_IDLE; // R4 R5
        end
      end
      ST_OFF:
      begin
        if (!enable || mode != MODE_ALT)
        begin
          next_state = ST_IDLE; // R7
        end
        else if (tick && remain == DUR_MIN)
        begin
          next_state = ST_ON; // R5
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      remain <= DUR_DEFAULT;
    end
    else if (next_state == ST_ON && state != ST_ON)
    begin
      remain <= time_on; // R1 R11
    end
    else if (next_state == ST_OFF && state != ST_OFF)
    begin
      remain <= time_off; // R7 R11
    end
    else if (tick && remain > DUR_MIN)
    begin
      remain <= remain - DUR_MIN;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dout <= 1'b0;
      selected_value <= 1'b0;
    end
    else
    begin
      dout <= next_state == ST_ON;
      selected_value <= next_state == ST_ON; // R10
    end
  end
endmodule

// ===== test/dpt_props.sv
// Port checker for the pulse timer
`timescale 1ns/10ps
module dpt_props
  import dpt_pkg::*;
#(
  parameter int TICK_DIV = 10
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dout,
  input wire logic selected_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic tk, tk_rd, lab, seen;
  logic [31:0] ph, ph0;
  assign tk = hsel && hready && htrans == HTRANS_NONSEQ;
  assign tk_rd = tk && !hwrite;
  assign lab = haddr[7:6] == 2'h0 && haddr[5] && haddr[3:2] != 2'h3;
  // ****
  // Tick phase of each fall
  // ****
  always_ff @(posedge sys_clk)
  begin
    ph <= (rst || ph == TICK_DIV - 1) ? ZERO_WORD : ph + 1;
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      seen <= 1'b0;
    else if ($fell(dout) && !seen)
    begin
      seen <= 1'b1;
      ph0 <= ph;
    end
  end
  sequence s_lab_rd;
    tk_rd && lab;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_sel_mirror: assert property (selected_value == dout)
    else $error("sel differs");
  a_lab_wait: assert property (s_lab_rd |=> s_one_wait)
    else $error("label wait");
  a_zero_wait: assert property (tk && !(lab && !hwrite) |=> hreadyout)
    else $error("bus wait");
  a_rd_hold: assert property ($changed(hrdata) |-> $past(tk_rd) || $past(tk_rd, 2))
    else $error("read data moved");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bad resp");
  a_fall_phase: assert property ($fell(dout) && seen |-> ph == ph0)
    else $error("fall off tick");
  a_rst_idle: assert property (disable iff (1'b0) rst |=> !dout)
    else $error("out after reset");
  a_rst_bus: assert property (disable iff (1'b0) rst |=> hreadyout && hrdata == 0)
    else $error("bus after reset");
endmodule
bind dpt_timer dpt_props #(.TICK_DIV(TICK_DIV)) u_props (.sys_clk(sys_clk), .rst(rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dout(dout),
  .selected_value(selected_value));

// ===== test/dpt_field.sv
// Field equipment model timing the output
`timescale 1ns/10ps
module dpt_field
(
  input wire logic sys_clk,
  input wire logic dout,
  output int rises,
  output int hi_len,
  output int lo_len
);
  int cnt = 0;
  logic last = 1'b0;
  always @(posedge sys_clk)
  begin
    if (dout !== last)
    begin
      if (last === 1'b1)
        hi_len = cnt;
      else
        lo_len = cnt;
      if (dout === 1'b1)
        rises++;
      cnt = 0;
    end
    cnt++;
    last = dout;
  end
endmodule

// ===== test/dpt_timer_tb_top.sv
// Self-checking bench for the pulse timer
`timescale 1ns/10ps
module dpt_timer_tb_top
  import dpt_pkg::*;
;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} dpt_row_t;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, dout, selected_value;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int rises, hi_len, lo_len, err_total, cmp_count, r0;
  logic [31:0] sv [3] = '{32'h0000_079E, 32'h0000_079F, 32'h0000_0B87};
  dpt_row_t rows [8] = '{
    '{1'b0, ADDR_TIME_ON, ZERO_WORD, 32'h0000_0064},
    '{1'b0, ADDR_TIME_OFF, ZERO_WORD, 32'h0000_0064},
    '{1'b1, 8'h1C, 32'h0000_1234, ZERO_WORD},
    '{1'b1, ADDR_TIME_OFF, ZERO_WORD, 32'h0000_0001},
    '{1'b1, ADDR_TIME_ON, ZERO_WORD, 32'h0000_0001},
    '{1'b1, ADDR_LABEL_ON, 32'h3231_4E4F, 32'h3231_4E4F},
    '{1'b1, 8'h38, 32'h0000_3938, 32'h0000_3938},
    '{1'b1, ADDR_TIME_ON, 32'h0000_0003, 32'h0000_0003}};
  dpt_timer #(.TICK_DIV(10)) dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .dout(dout), .selected_value(selected_value));
  dpt_field u_field (.sys_clk(sys_clk), .dout(dout), .rises(rises), .hi_len(hi_len),
    .lo_len(lo_len));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("mismatch %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    wt(5000);
    err_total++;
    test_done;
  end
  initial
  begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = ZERO_WORD;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = ZERO_WORD;
    wt(4);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, ZERO_WORD);
      chk("reg", rows[i].e, q);
    end
    $display("regs done");
    r0 = rises;
    bus(1'b1, ADDR_CTRL, 32'h0000_0005);
    bus(1'b1, ADDR_TRIG, 32'h0000_0001);
    wt(60);
    chk("single_n", r0 + 1, rises);
    chk("single_w", 32'h1, 32'(hi_len > 20 && hi_len <= 30));
    r0 = rises;
    bus(1'b1, ADDR_CTRL, 32'h0000_0004);
    bus(1'b1, ADDR_TRIG, 32'h0000_0001);
    wt(60);
    chk("other_n", r0, rises);
    $display("single done");
    bus(1'b1, ADDR_VALUE, 32'h0000_03B6);
    bus(1'b1, ADDR_STEP, 32'h0000_03E8);
    bus(1'b1, ADDR_CTRL, 32'h0000_0007);
    r0 = rises;
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, ADDR_VALUE, sv[k]);
      wt(40);
      chk("scaled_n", r0 + k, rises);
    end
    $display("scaled done");
    bus(1'b1, ADDR_CTRL, ZERO_WORD);
    bus(1'b1, ADDR_TIME_ON, 32'h0000_0001);
    bus(1'b1, ADDR_TIME_OFF, 32'h0000_0003);
    bus(1'b1, ADDR_CTRL, 32'h0000_0006);
    wt(150);
    chk("alt_hi", 32'd10, hi_len);
    chk("alt_lo", 32'd30, lo_len);
    chk("alt_sel", {31'h0, dout}, {31'h0, selected_value});
    $display("alt done");
    rst <= 1'b1;
    wt(4);
    rst <= 1'b0;
    chk("rst_out", ZERO_WORD, {31'h0, dout});
    r0 = rises;
    bus(1'b0, ADDR_TIME_ON, ZERO_WORD);
    chk("rst_on", 32'h0000_0064, q);
    bus(1'b0, ADDR_STATUS, ZERO_WORD);
    chk("rst_stat", 32'h0000_0004, q);
    wt(100);
    chk("rst_n", r0, rises);
    $display("reset done");
    test_done;
  end
endmodule
